// ===== verilog/cild_decode.sv
// Notes on behaviour
// (RL1) Fields: opcode, coproc index, base, index, xo
// (RL2) Address is base plus index register
// (RL3) Base field zero means zero base
// (RL4) Xo 7: sign-extended byte load to coprocessor
// (RL5) Xo 39: halfword aligned, sign-extended load
// (RL6) Xo 71: word aligned single word load
// (RL7) Xo 263: two words, address and plus four
// (RL8) Xo 103: four words up to plus twelve
// (RL9) Coprocessor builds its register from words
// (RL10) Byte, halfword lane is eight times address
// (RL11) Loads: user no-access zone gives storage fault
// (RL12) No translation match gives TLB miss
// (RL13) Reserved bits set: bounded, no program trap
// (RL14) Xo 647: store lowest byte at address
// (RL15) Xo 679: halfword aligned two-byte store
// (RL16) Update stores write address back to base
// (RL17) Read-only zone store faults in every mode
// (RL18) Store no-access check only in user mode
// (RL19) Update store with base zero: bounded result
module cild_decode
    import cild_pkg::*;
#(
    parameter int GPR_COUNT = 32
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] gpr_rd_a,
    input wire logic [31:0] gpr_rd_b,
    input wire logic reloc_en,
    input wire logic user_mode,
    input wire logic tlb_hit,
    input wire logic zone_no_access,
    input wire logic zone_read_only,
    input wire logic mem_ack,
    input wire logic [127:0] mem_rdata,
    input wire logic [31:0] cp_store_data,
    output logic busy,
    output logic [4:0] gpr_sel_a,
    output logic [4:0] gpr_sel_b,
    output logic [31:0] effective_address,
    output logic mem_req,
    output logic mem_we,
    output logic [3:0] mem_be,
    output logic [7:0] mem_wdata_byte_hi,
    output logic [7:0] mem_wdata_byte_lo,
    output logic cp_load_valid,
    output logic [31:0] cp_load_data,
    output logic [4:0] coproc_reg_index,
    output logic [1:0] cp_beat,
    output logic cp_last,
    output logic cp_store_take,
    output logic gpr_wr_en,
    output logic [4:0] gpr_wr_sel,
    output logic [31:0] gpr_wr_data,
    output logic exc_data_storage,
    output logic exc_dtlb_miss,
    output logic done
);

`include "cild_cfg.svh"

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic hit;
    logic is_store;
    logic is_update;
    cild_size_t size;
    logic [4:0] cri;
    logic [4:0] base_sel;
    logic [4:0] idx_sel;

    cild_field_decode u_field
    (
        .instr(instr),
        .hit(hit),
        .is_store(is_store),
        .is_update(is_update),
        .size(size),
        .cri(cri),
        .base_sel(base_sel),
        .idx_sel(idx_sel)
    );

    // Register file read ports are combinational on the core side
    assign gpr_sel_a = base_sel;
    assign gpr_sel_b = idx_sel;

    // ------------------------------------------------------------
    // Address generation
    // ------------------------------------------------------------
    logic [31:0] base_val;
    logic [31:0] ea_raw;
    logic [31:0] ea_aligned;

    always_comb
    begin
        base_val = (base_sel == 5'h00) ? 32'h0000_0000 : gpr_rd_a; // RL3 RL19
        ea_raw = base_val + gpr_rd_b; // RL2
        case (size)
            CILD_SZ_BYTE: ea_aligned = ea_raw; // RL4 RL14
            CILD_SZ_HALF: ea_aligned = {ea_raw[31:1], 1'b0}; // RL5 RL15
            default: ea_aligned = {ea_raw[31:2], 2'b00}; // RL6 RL7 RL8
        endcase
    end

    // ------------------------------------------------------------
    // Protection checks
    // ------------------------------------------------------------
    logic fault_tlb;
    logic fault_storage;

    always_comb
    begin
        fault_tlb = reloc_en && !tlb_hit; // RL12
        if (is_store)
        begin
            fault_storage = reloc_en && (zone_read_only || (user_mode && zone_no_access)); // RL17 RL18
        end
        else
        begin
            fault_storage = reloc_en && user_mode && zone_no_access; // RL11
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    cild_state_t state_q;
    logic [31:0] ea_q;
    cild_size_t size_q;
    logic upd_q;
    logic [4:0] base_q;
    logic [1:0] beat_q;
    logic [1:0] last_beat;
    logic [31:0] byte_ext;

    always_comb
    begin
        case (size_q)
            CILD_SZ_DBL: last_beat = 2'h1; // RL7
            CILD_SZ_QUAD: last_beat = 2'h3; // RL8
            default: last_beat = 2'h0;
        endcase
    end

    cild_lane_align u_align
    (
        .line(mem_rdata),
        .lane(ea_q[3:0]),
        .half(size_q == CILD_SZ_HALF),
        .ext(byte_ext)
    );

    logic start;
    assign start = instr_valid && hit && state_q == CILD_IDLE;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state_q <= CILD_IDLE;
            ea_q <= 32'h0000_0000;
            size_q <= CILD_SZ_BYTE;
            upd_q <= 1'b0;
            base_q <= 5'h00;
            beat_q <= 2'h0;
        end
        else if (ce)
        begin
            case (state_q)
                CILD_IDLE:
                begin
                    beat_q <= 2'h0;
                    if (start && !fault_tlb && !fault_storage)
                    begin
                        ea_q <= ea_aligned;
                        size_q <= size;
                        upd_q <= is_update;
                        base_q <= base_sel;
                        state_q <= is_store ? CILD_STORE : CILD_LOAD;
                    end
                end
                CILD_LOAD:
                begin
                    if (mem_ack)
                    begin
                        if (beat_q == last_beat)
                        begin
                            state_q <= CILD_DONE;
                        end
                        else
                        begin
                            beat_q <= beat_q + 2'h1;
                            ea_q <= ea_q + `CILD_WORD_STEP; // RL7 RL8
                        end
                    end
                end
                CILD_STORE:
                begin
                    if (mem_ack)
                    begin
                        state_q <= CILD_DONE;
                    end
                end
                CILD_DONE: state_q <= CILD_IDLE;
                default: state_q <= CILD_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Memory request outputs
    // ------------------------------------------------------------
    logic [31:0] ea_wb_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            busy <= 1'b0;
            effective_address <= 32'h0000_0000;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_be <= 4'h0;
            mem_wdata_byte_hi <= 8'h00;
            mem_wdata_byte_lo <= 8'h00;
            cp_store_take <= 1'b0;
            ea_wb_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            cp_store_take <= 1'b0;
            if (start && !fault_tlb && !fault_storage)
            begin
                busy <= 1'b1;
                effective_address <= ea_aligned;
                ea_wb_q <= ea_aligned;
                mem_req <= 1'b1;
                mem_we <= is_store;
                cp_store_take <= is_store;
                // Byte enables follow big-endian lane order within a word
                case (size)
                    CILD_SZ_BYTE: mem_be <= 4'h8 >> ea_aligned[1:0]; // RL14
                    CILD_SZ_HALF: mem_be <= ea_aligned[1] ? 4'h3 : 4'hC; // RL15
                    default: mem_be <= 4'hF;
                endcase
                mem_wdata_byte_hi <= cp_store_data[15:8]; // RL15
                mem_wdata_byte_lo <= cp_store_data[7:0]; // RL14
            end
            else if (mem_req && mem_ack)
            begin
                if (state_q == CILD_LOAD && beat_q != last_beat)
                begin
                    effective_address <= effective_address + `CILD_WORD_STEP;
                end
                else
                begin
                    mem_req <= 1'b0;
                    mem_we <= 1'b0;
                    busy <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Coprocessor delivery
    // ------------------------------------------------------------
    // The coprocessor owns how beats are packed into its register
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            cp_load_valid <= 1'b0;
            cp_load_data <= 32'h0000_0000;
            coproc_reg_index <= 5'h00;
            cp_beat <= 2'h0;
            cp_last <= 1'b0;
        end
        else if (ce)
        begin
            cp_load_valid <= 1'b0;
            if (start)
            begin
                coproc_reg_index <= cri; // RL4
            end
            if (state_q == CILD_LOAD && mem_ack)
            begin
                cp_load_valid <= 1'b1; // RL9
                cp_beat <= beat_q;
                cp_last <= beat_q == last_beat;
                if (size_q == CILD_SZ_BYTE || size_q == CILD_SZ_HALF)
                begin
                    cp_load_data <= byte_ext; // RL4 RL5 RL10
                end
                else
                begin
                    cp_load_data <= mem_rdata[127 - 32 * ea_q[3:2] -: 32]; // RL6
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Base write-back and exceptions
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            gpr_wr_en <= 1'b0;
            gpr_wr_sel <= 5'h00;
            gpr_wr_data <= 32'h0000_0000;
            exc_data_storage <= 1'b0;
            exc_dtlb_miss <= 1'b0;
            done <= 1'b0;
        end
        else if (ce)
        begin
            gpr_wr_en <= 1'b0;
            exc_data_storage <= 1'b0;
            exc_dtlb_miss <= 1'b0;
            done <= 1'b0;
            if (start)
            begin
                exc_dtlb_miss <= fault_tlb; // RL12
                exc_data_storage <= !fault_tlb && fault_storage; // RL11 RL17
            end
            if (state_q == CILD_STORE && mem_ack)
            begin
                // Base field zero still writes, register zero takes the address
                gpr_wr_en <= upd_q; // RL16 RL19
                gpr_wr_sel <= base_q;
                gpr_wr_data <= ea_wb_q; // RL16
            end
            if (state_q == CILD_DONE)
            begin
                done <= 1'b1;
            end
        end
    end

endmodule : cild_decode

// ===== verilog/cild_cfg.svh
`ifndef CILD_CFG_SVH
`define CILD_CFG_SVH

// Instruction fields, bit 0 is the least significant bit of the word
`define CILD_PRIM_HI 31
`define CILD_PRIM_LO 26
`define CILD_CRI_HI 25
`define CILD_CRI_LO 21
`define CILD_BASE_HI 20
`define CILD_BASE_LO 16
`define CILD_IDX_HI 15
`define CILD_IDX_LO 11
`define CILD_XO_HI 10
`define CILD_XO_LO 1
`define CILD_RSV_BIT 0

`define CILD_PRIM_OP 6'h1F
`define CILD_XO_LB 10'h007
`define CILD_XO_LH 10'h027
`define CILD_XO_LW 10'h047
`define CILD_XO_LD 10'h107
`define CILD_XO_LQ 10'h067
`define CILD_XO_STBU 10'h287
`define CILD_XO_STHU 10'h2A7

`define CILD_WORD_STEP 32'h0000_0004

`endif

// ===== verilog/cild_pkg.sv
package cild_pkg;

    typedef enum logic [3:0]
    {
        CILD_IDLE = 4'b0001,
        CILD_LOAD = 4'b0010,
        CILD_STORE = 4'b0100,
        CILD_DONE = 4'b1000
    } cild_state_t;

    typedef enum logic [2:0]
    {
        CILD_SZ_BYTE = 3'h0,
        CILD_SZ_HALF = 3'h1,
        CILD_SZ_WORD = 3'h2,
        CILD_SZ_DBL = 3'h3,
        CILD_SZ_QUAD = 3'h4
    } cild_size_t;

endpackage : cild_pkg

// ===== verilog/cild_field_decode.sv
`include "cild_cfg.svh"

module cild_field_decode
    import cild_pkg::*;
(
    input wire logic [31:0] instr,
    output logic hit,
    output logic is_store,
    output logic is_update,
    output cild_size_t size,
    output logic [4:0] cri,
    output logic [4:0] base_sel,
    output logic [4:0] idx_sel
);

    logic [9:0] xo;

    assign cri = instr[`CILD_CRI_HI:`CILD_CRI_LO]; // RL1
    assign base_sel = instr[`CILD_BASE_HI:`CILD_BASE_LO]; // RL1
    assign idx_sel = instr[`CILD_IDX_HI:`CILD_IDX_LO]; // RL1
    assign xo = instr[`CILD_XO_HI:`CILD_XO_LO]; // RL1

    // Reserved bit is ignored so such forms still execute, never trap
    always_comb
    begin
        hit = instr[`CILD_PRIM_HI:`CILD_PRIM_LO] == `CILD_PRIM_OP; // RL13
        is_store = 1'b0;
        is_update = 1'b0;
        size = CILD_SZ_BYTE;
        case (xo)
            `CILD_XO_LB: size = CILD_SZ_BYTE; // RL4
            `CILD_XO_LH: size = CILD_SZ_HALF; // RL5
            `CILD_XO_LW: size = CILD_SZ_WORD; // RL6
            `CILD_XO_LD: size = CILD_SZ_DBL; // RL7
            `CILD_XO_LQ: size = CILD_SZ_QUAD; // RL8
            `CILD_XO_STBU:
            begin
                is_store = 1'b1; // RL14
                is_update = 1'b1;
            end
            `CILD_XO_STHU:
            begin
                is_store = 1'b1; // RL15
                is_update = 1'b1;
                size = CILD_SZ_HALF;
            end
            default: hit = 1'b0;
        endcase
    end

endmodule : cild_field_decode

// ===== verilog/cild_lane_align.sv
module cild_lane_align
(
    input wire logic [127:0] line,
    input wire logic [3:0] lane,
    input wire logic half,
    output logic [31:0] ext
);

    logic [127:0] shifted;

    // Byte lane eb = 8 * low four address bits, counted from the line's top
    always_comb
    begin
        shifted = line << {lane, 3'b000}; // RL10
        if (half)
        begin
            ext = {{16{shifted[127]}}, shifted[127:112]}; // RL5
        end
        else
        begin
            ext = {{24{shifted[127]}}, shifted[127:120]}; // RL4
        end
    end

endmodule : cild_lane_align

// ===== verif/cild_checker.sv
module cild_checker
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] gpr_rd_a,
    input wire logic [31:0] gpr_rd_b,
    input wire logic reloc_en,
    input wire logic user_mode,
    input wire logic tlb_hit,
    input wire logic zone_no_access,
    input wire logic zone_read_only,
    input wire logic busy,
    input wire logic [31:0] effective_address,
    input wire logic mem_req,
    input wire logic [3:0] mem_be,
    input wire logic gpr_wr_en,
    input wire logic [31:0] gpr_wr_data,
    input wire logic exc_data_storage,
    input wire logic exc_dtlb_miss,
    input wire logic done
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Start of an instruction
    // ----------------------------------------
    logic take;
    logic st;
    logic busy_d;
    logic [9:0] xo;
    // Busy one enabled edge ago marks the closing cycle, in which a new instruction is refused
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            busy_d <= 1'b0;
        end
        else if (ce)
        begin
            busy_d <= busy;
        end
    end
    assign xo = instr[10:1];
    assign take = ce && instr_valid && !busy && !busy_d && instr[31:26] == 6'h1F;
    // Translated store start, zone checks decide the outcome
    assign st = take && (xo == 10'h287 || xo == 10'h2A7) && reloc_en && tlb_hit;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    property p_ea_sum;
        take && xo == 10'h007 && instr[20:16] != 5'h00 && !reloc_en |=> effective_address == $past(gpr_rd_a) + $past(gpr_rd_b);
    endproperty
    a_ea_sum: assert property (p_ea_sum) else $error("address sum wrong");
    property p_word_align;
        take && xo == 10'h047 && !reloc_en |=> effective_address[1:0] == 2'b00;
    endproperty
    a_word_align: assert property (p_word_align) else $error("word address not aligned");
    property p_tlb;
        take && xo == 10'h007 && reloc_en && !tlb_hit |=> exc_dtlb_miss && !mem_req;
    endproperty
    a_tlb: assert property (p_tlb) else $error("missing translation fault");
    property p_na_load;
        take && xo == 10'h047 && reloc_en && tlb_hit && user_mode && zone_no_access |=> exc_data_storage;
    endproperty
    a_na_load: assert property (p_na_load) else $error("user load fault missing");
    property p_ro;
        st && zone_read_only |=> exc_data_storage && !mem_req;
    endproperty
    a_ro: assert property (p_ro) else $error("read-only store fault missing");
    property p_priv;
        st && !user_mode && zone_no_access && !zone_read_only |=> mem_req && !exc_data_storage;
    endproperty
    a_priv: assert property (p_priv) else $error("privileged store wrongly faulted");
    property p_be;
        take && xo == 10'h287 && !reloc_en |=> mem_be == 4'b1000 >> effective_address[1:0];
    endproperty
    a_be: assert property (p_be) else $error("byte lane wrong");
    property p_upd;
        gpr_wr_en |-> gpr_wr_data == effective_address;
    endproperty
    a_upd: assert property (p_upd) else $error("base update value wrong");
    property p_upd_end;
        gpr_wr_en && ce |=> done;
    endproperty
    a_upd_end: assert property (p_upd_end) else $error("done missing after base update");
endmodule : cild_checker

// ===== verif/cild_cp_model.sv
module cild_cp_model
(
    input wire logic mclk,
    input wire logic cp_load_valid,
    input wire logic [31:0] cp_load_data,
    input wire logic [1:0] cp_beat,
    output logic [31:0] cp_store_data,
    output logic [127:0] cp_reg_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Coprocessor register build
    // ----------------------------------------
    // Fixed source so store lanes are easy to predict
    assign cp_store_data = 32'h5AC3_9E71;
    always_ff @(posedge mclk)
    begin
        if (cp_load_valid)
        begin
            cp_reg_q[127 - 32 * cp_beat -: 32] <= cp_load_data;
        end
    end
endmodule : cild_cp_model

// ===== verif/tb.sv
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("ERROR %0t got %h want %h", $time, g, e); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [127:0] LINE = 128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic instr_valid = 1'b0;
    logic [31:0] instr = 32'h0000_0000;
    logic reloc_en = 1'b0, user_mode = 1'b0, tlb_hit = 1'b1, zone_no_access = 1'b0, zone_read_only = 1'b0;
    logic mem_ack = 1'b0;
    logic [127:0] mem_rdata, cp_reg_q;
    logic [31:0] gpr_rd_a, gpr_rd_b, effective_address, cp_load_data, cp_store_data, gpr_wr_data;
    logic busy, mem_req, mem_we, cp_load_valid, cp_last, cp_store_take, gpr_wr_en, exc_data_storage, exc_dtlb_miss;
    logic done, fin;
    logic [4:0] gpr_sel_a, gpr_sel_b, coproc_reg_index, gpr_wr_sel, ws_s, cri_s;
    logic [3:0] mem_be, be_s;
    logic [7:0] mem_wdata_byte_hi, mem_wdata_byte_lo;
    logic [1:0] cp_beat;
    logic [31:0] gpr [32];
    logic [31:0] ea_s, cd_s, wd_s;
    logic [15:0] sd_s;
    logic [1:0] wt_s;
    logic [2:0] lb_s;
    int beats, n_ds, n_tlb, n_wr, n_last, slow, wait_q, cycles, bad_count, checked;
    cild_decode u_dut (.*);
    cild_cp_model u_cp (.*);
    always #2.5 mclk = ~mclk;
    assign gpr_rd_a = gpr[gpr_sel_a];
    assign gpr_rd_b = gpr[gpr_sel_b];
    // Line is only valid with the ack, so a late sample shows wrong bytes
    assign mem_rdata = mem_ack ? LINE : ~LINE;
    // ----------------------------------------
    // Memory responder and watchdog
    // ----------------------------------------
    always @(negedge mclk)
    begin
        mem_ack <= mem_req && !mem_ack && wait_q >= slow;
        wait_q <= (mem_req && !mem_ack && wait_q < slow) ? wait_q + 1 : 0;
    end
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic issue(input logic [9:0] xo, input logic [4:0] ra, input logic [4:0] rb, input logic rsv);
        @(negedge mclk);
        instr <= {6'h1F, 5'd9, ra, rb, xo, rsv};
        instr_valid <= 1'b1;
        {beats, n_ds, n_tlb, n_wr, n_last, fin} = '0;
        @(negedge mclk);
        instr_valid <= 1'b0;
        for (int i = 0; i < 40 && !fin; i++)
        begin
            if (i == 0)
                {ea_s, be_s, sd_s} = {effective_address, mem_be, mem_wdata_byte_hi, mem_wdata_byte_lo};
            if (i == 0)
                wt_s = {mem_we, cp_store_take};
            if (cp_load_valid)
                {beats, cd_s, cri_s, lb_s} = {beats + 1, cp_load_data, coproc_reg_index, cp_beat, cp_last};
            if (gpr_wr_en)
                {n_wr, ws_s, wd_s} = {n_wr + 1, gpr_wr_sel, gpr_wr_data};
            n_ds += exc_data_storage;
            n_tlb += exc_dtlb_miss;
            n_last += cp_load_valid && cp_last;
            fin = done || exc_data_storage || exc_dtlb_miss;
            if (!fin)
                @(negedge mclk);
        end
    endtask : issue
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_loads();
        gpr[3] = 32'h0000_1000;
        gpr[4] = 32'h0000_0005;
        issue(10'h007, 5'd3, 5'd4, 1'b0);
        `CHK(ea_s, 32'h0000_1005)
        `CHK(cd_s, 32'hFFFF_FFA5)
        `CHK(cri_s, 5'd9)
        gpr[4] = 32'h0000_0007;
        issue(10'h027, 5'd3, 5'd4, 1'b0);
        `CHK({ea_s, cd_s}, {32'h0000_1006, 32'hFFFF_9687})
        gpr[4] = 32'h0000_000B;
        issue(10'h047, 5'd3, 5'd4, 1'b0);
        `CHK({ea_s, cd_s}, {32'h0000_1008, 32'h7869_5A4B})
        `CHK({wt_s, lb_s}, {2'b00, 3'b001})
        gpr[0] = 32'h0000_7770;
        gpr[4] = 32'h0000_0005;
        issue(10'h007, 5'd0, 5'd4, 1'b0);
        `CHK(ea_s, 32'h0000_0005)
    endtask : t_loads
    task automatic t_multi();
        slow = 2;
        gpr[4] = 32'h0000_0002;
        issue(10'h107, 5'd3, 5'd4, 1'b0);
        `CHK(beats, 2)
        `CHK(cp_reg_q[127:64], LINE[127:64])
        issue(10'h067, 5'd3, 5'd4, 1'b0);
        `CHK(beats, 4)
        `CHK(cp_reg_q, LINE)
        `CHK({lb_s, n_last}, {3'b111, 32'd1})
        slow = 0;
    endtask : t_multi
    task automatic t_stores();
        gpr[6] = 32'h0000_2000;
        gpr[4] = 32'h0000_0003;
        issue(10'h287, 5'd6, 5'd4, 1'b0);
        `CHK({be_s, sd_s[7:0]}, {4'b0001, 8'h71})
        `CHK(wt_s, 2'b11)
        `CHK({n_wr, ws_s, wd_s}, {32'd1, 5'd6, 32'h0000_2003})
        gpr[4] = 32'h0000_0007;
        issue(10'h2A7, 5'd6, 5'd4, 1'b0);
        `CHK({be_s, sd_s, wd_s}, {4'b0011, 16'h9E71, 32'h0000_2006})
        issue(10'h287, 5'd0, 5'd4, 1'b0);
        `CHK({fin, n_ds}, {1'b1, 32'd0})
    endtask : t_stores
    task automatic t_faults();
        {reloc_en, tlb_hit} = 2'b10;
        issue(10'h007, 5'd3, 5'd4, 1'b0);
        `CHK({n_tlb, n_ds, beats}, {32'd1, 32'd0, 32'd0})
        {tlb_hit, user_mode, zone_no_access} = 3'b111;
        issue(10'h047, 5'd3, 5'd4, 1'b0);
        `CHK(n_ds, 1)
        user_mode = 1'b0;
        issue(10'h287, 5'd6, 5'd4, 1'b0);
        `CHK({n_ds, n_wr}, {32'd0, 32'd1})
        {zone_no_access, zone_read_only} = 2'b01;
        issue(10'h2A7, 5'd6, 5'd4, 1'b0);
        `CHK({n_ds, n_wr}, {32'd1, 32'd0})
        {reloc_en, zone_read_only} = 2'b00;
        issue(10'h047, 5'd3, 5'd4, 1'b1);
        `CHK({fin, n_ds, n_tlb}, {1'b1, 32'd0, 32'd0})
        issue(10'h3FF, 5'd3, 5'd4, 1'b0);
        `CHK(fin, 1'b0)
        // A frozen block must not take an instruction offered meanwhile
        ce = 1'b0;
        issue(10'h047, 5'd3, 5'd4, 1'b0);
        `CHK({fin, beats}, {1'b0, 32'd0})
        ce = 1'b1;
    endtask : t_faults
    initial
    begin
        foreach (gpr[i])
            gpr[i] = 32'h0000_0000;
        repeat (3) @(negedge mclk);
        rst_b <= 1'b1;
        t_loads();
        t_multi();
        t_stores();
        t_faults();
        print_verdict();
    end
endmodule : tb

bind cild_decode cild_checker u_chk (.*);
